/* File: logic/cantrx_pkg.sv */
// Package: constants and carrier types for the CAN transceiver mode and wake control
package cantrx_pkg;
   // Clock
   localparam int CLK_MHZ = 50;
   // Times in microseconds as printed defaults (plain values, not from any part)
   localparam int ENABLE_DELAY_US = 50;
   localparam int WAKE_TIME_MIN_US = 1;
   localparam int WAKE_TIME_MAX_US = 1000;
   localparam int SILENCE_US = 1000;
   localparam int TRANSMIT_TIMEOUT_US = 2000;
   localparam int BUS_CLAMP_TIMEOUT_US = 4000;
   // Cycle counts; least times round up, longest round down
   localparam int ENABLE_DELAY_CYC = ENABLE_DELAY_US * CLK_MHZ;
   localparam int WAKE_MIN_CYC = WAKE_TIME_MIN_US * CLK_MHZ;
   localparam int WAKE_MAX_CYC = WAKE_TIME_MAX_US * CLK_MHZ;
   localparam int SILENCE_CYC = SILENCE_US * CLK_MHZ;
   localparam int TX_TO_CYC = TRANSMIT_TIMEOUT_US * CLK_MHZ;
   localparam int CLAMP_CYC = BUS_CLAMP_TIMEOUT_US * CLK_MHZ;
   localparam int CNT_W = 24;
   // Register map (word byte addresses)
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STAT = 4'h4;
   localparam logic [3:0] ADDR_WAKE = 4'h8;
   // Transceiver mode codes; wake capable is fixed, others chosen
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_WAKE = 2'h1;
   localparam logic [1:0] MODE_RXONLY = 2'h2;
   localparam logic [1:0] MODE_NORMAL = 2'h3;
   // Control field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_WDWAKE_BIT = 2;
   localparam logic [1:0] MODE_RESET = 2'h0;
   // Chip operating modes
   typedef enum logic [2:0] {
      CHIP_NORMAL, CHIP_STOP, CHIP_SLEEP, CHIP_RESTART, CHIP_FAILSAFE
   } chip_mode_t;
   // Bus-side pin group
   typedef struct packed {
      logic drive_dom;
      logic term_gnd;
      logic term_mid;
   } bus_drv_t;
endpackage

/* File: logic/can_trx_ctrl.sv */
// Design: CAN transceiver mode, wake detection and transmit supervision
// Function
// - Start off; off ignores bus wake
// - Normal mode selectable only in chip normal
// - Normal: low transmit input drives dominant
// - After enable delay send only fresh dominant
// - Receive output follows bus when receiving
// - Receive-only disables driver, receives
// - Receive-only selectable only in chip normal/stop
// - Wake capable selectable; forced in fail-safe
// - Wake drives receive output low until change
// - Pattern: dominant, recessive, dominant within window
// - Mode field still reads wake capable
// - Wake disarmed until mode toggled
// - Chip stop/sleep/fail-safe rearms detection
// - Stop/normal wake: interrupt and status
// - Stop wake re-enables watchdog if configured
// - Sleep wake: restart then normal, no interrupt
// - Ground termination after silence time
// - Long transmit dominant forces recessive
// - Time-out sets failure flag, mode kept
// - Transmitter resumes once dominant removed
// - Bus clamp sets failure flag
`timescale 1ns/1ps
module can_trx_ctrl (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Avalon-MM slave
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Controller side
   input wire logic tx_data_in_i,
   output logic rx_data_out_o,
   output logic irq_n_out_o,
   // Bus side
   input wire logic bus_dominant_i,
   output cantrx_pkg::bus_drv_t bus_o,
   // Chip level
   input wire cantrx_pkg::chip_mode_t chip_mode_i,
   input wire logic watchdog_off_i,
   output logic watchdog_wake_en_o,
   output logic chip_wake_restart_o
);
   // ==========================================
   // Input synchronisers
   logic [1:0] tx_sync_ff;
   logic [1:0] bus_sync_ff;
   logic txd;
   logic busd;
   // Pins are asynchronous: two stages before use
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_sync_ff <= 2'h3;
         bus_sync_ff <= 2'h0;
      end else begin
         tx_sync_ff <= {tx_sync_ff[0], tx_data_in_i};
         bus_sync_ff <= {bus_sync_ff[0], bus_dominant_i};
      end
   end
   assign txd = tx_sync_ff[1];
   assign busd = bus_sync_ff[1];

   // ==========================================
   // Registers
   logic [1:0] mode_ff;
   logic wdwake_ff;
   logic fail_ff;
   logic wake_stat_ff;
   logic armed_ff;
   logic woken_ff;
   logic wake_evt;
   logic wr_ctrl;
   logic [1:0] req_mode;
   logic mode_ok;
   cantrx_pkg::chip_mode_t chip_q_ff;
   logic tx_to_evt;
   logic clamp_evt;
   logic rd_wait_ff;
   logic rd_take;
   // Reads wait one cycle so the registered data stands at the accepting edge
   assign avs_waitrequest_o = avs_read_i && !rd_wait_ff;
   assign rd_take = avs_read_i && !rd_wait_ff;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_wait_ff <= 1'b0;
      end else begin
         rd_wait_ff <= rd_take;
      end
   end
   assign wr_ctrl = avs_write_i && (avs_address_i == cantrx_pkg::ADDR_CTRL);
   assign req_mode = avs_writedata_i[cantrx_pkg::CTRL_MODE_LSB +: 2];

   // Legality of a requested mode per chip mode
   always_comb begin
      unique case (req_mode)
         cantrx_pkg::MODE_OFF: mode_ok = 1'b1;
         cantrx_pkg::MODE_NORMAL: mode_ok = (chip_mode_i == cantrx_pkg::CHIP_NORMAL);
         cantrx_pkg::MODE_RXONLY: mode_ok = (chip_mode_i == cantrx_pkg::CHIP_NORMAL) ||
                                            (chip_mode_i == cantrx_pkg::CHIP_STOP);
         cantrx_pkg::MODE_WAKE: mode_ok = (chip_mode_i != cantrx_pkg::CHIP_FAILSAFE);
      endcase
   end

   // Mode register; fail-safe forces wake capable, wake never changes the code
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mode_ff <= cantrx_pkg::MODE_RESET;
      end else if (chip_mode_i == cantrx_pkg::CHIP_FAILSAFE) begin
         mode_ff <= cantrx_pkg::MODE_WAKE;
      end else if (wr_ctrl && mode_ok) begin
         mode_ff <= req_mode;
      end
   end

   // Watchdog-on-wake configuration
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wdwake_ff <= 1'b0;
      end else if (wr_ctrl) begin
         wdwake_ff <= avs_writedata_i[cantrx_pkg::CTRL_WDWAKE_BIT];
      end
   end

   // Chip mode history for change detection
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         chip_q_ff <= cantrx_pkg::CHIP_NORMAL;
      end else begin
         chip_q_ff <= chip_mode_i;
      end
   end

   // Arming: a mode write away from wake capable rearms the next entry
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         armed_ff <= 1'b1;
      end else if (wake_evt) begin
         armed_ff <= 1'b0;
      end else if (chip_mode_i != chip_q_ff &&
                   (chip_mode_i == cantrx_pkg::CHIP_STOP ||
                    chip_mode_i == cantrx_pkg::CHIP_SLEEP ||
                    chip_mode_i == cantrx_pkg::CHIP_FAILSAFE)) begin
         armed_ff <= 1'b1;
      end else if (mode_ff != cantrx_pkg::MODE_WAKE) begin
         armed_ff <= 1'b1;
      end
   end

   // Woken state holds rx low until another mode
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         woken_ff <= 1'b0;
      end else if (wake_evt) begin
         woken_ff <= 1'b1;
      end else if (mode_ff != cantrx_pkg::MODE_WAKE) begin
         woken_ff <= 1'b0;
      end
   end

   // ==========================================
   // Wake pattern recogniser
   typedef enum logic [1:0] {WP_IDLE, WP_DOM1, WP_REC, WP_DOM2} wp_state_t;
   wp_state_t wp_ff;
   logic [cantrx_pkg::CNT_W-1:0] wp_cnt_ff;
   logic wp_on;
   logic wp_prev_ff;
   logic in_win;
   // Off mode never listens; disarmed detector is idle
   assign wp_on = (mode_ff == cantrx_pkg::MODE_WAKE) && armed_ff;
   assign in_win = (wp_cnt_ff >= cantrx_pkg::CNT_W'(cantrx_pkg::WAKE_MIN_CYC)) &&
                   (wp_cnt_ff < cantrx_pkg::CNT_W'(cantrx_pkg::WAKE_MAX_CYC));
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wp_prev_ff <= 1'b0;
      end else begin
         wp_prev_ff <= busd;
      end
   end
   // Phase counter restarts on each bus edge
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wp_cnt_ff <= '0;
      end else if (busd != wp_prev_ff) begin
         wp_cnt_ff <= '0;
      end else if (wp_cnt_ff != '1) begin
         wp_cnt_ff <= wp_cnt_ff + 1'b1;
      end
   end
   // The first dominant and the recessive phase must end inside the window
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wp_ff <= WP_IDLE;
      end else if (!wp_on) begin
         wp_ff <= WP_IDLE;
      end else begin
         unique case (wp_ff)
            WP_IDLE: if (busd && !wp_prev_ff) wp_ff <= WP_DOM1;
            WP_DOM1: if (!busd) wp_ff <= in_win ? WP_REC : WP_IDLE;
            WP_REC: if (busd) wp_ff <= in_win ? WP_DOM2 : WP_DOM1; // Bad gap: fresh start
            WP_DOM2: if (!busd || !in_win && wp_cnt_ff >=
                          cantrx_pkg::CNT_W'(cantrx_pkg::WAKE_MAX_CYC)) wp_ff <= WP_IDLE;
         endcase
      end
   end
   // Wake fires when the second dominant reaches the minimum
   assign wake_evt = wp_on && (wp_ff == WP_DOM2) && busd &&
                     (wp_cnt_ff == cantrx_pkg::CNT_W'(cantrx_pkg::WAKE_MIN_CYC));

   // ==========================================
   // Wake reporting per chip mode
   logic irq_ff;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wake_stat_ff <= 1'b0;
         irq_ff <= 1'b0;
         watchdog_wake_en_o <= 1'b0;
         chip_wake_restart_o <= 1'b0;
      end else begin
         // Set wins over a clear-on-read in the same cycle
         if (wake_evt) begin
            wake_stat_ff <= 1'b1;
         end else if (rd_take && avs_address_i == cantrx_pkg::ADDR_WAKE) begin
            wake_stat_ff <= 1'b0;
            irq_ff <= 1'b0;
         end
         if (wake_evt && (chip_mode_i == cantrx_pkg::CHIP_STOP ||
                          chip_mode_i == cantrx_pkg::CHIP_NORMAL)) begin
            irq_ff <= 1'b1;
         end
         watchdog_wake_en_o <= wake_evt && chip_mode_i == cantrx_pkg::CHIP_STOP &&
                               watchdog_off_i && wdwake_ff;
         chip_wake_restart_o <= wake_evt && (chip_mode_i == cantrx_pkg::CHIP_SLEEP ||
                                chip_mode_i == cantrx_pkg::CHIP_FAILSAFE);
      end
   end
   assign irq_n_out_o = !irq_ff;

   // ==========================================
   // Enable delay and fresh-dominant gate
   logic [cantrx_pkg::CNT_W-1:0] en_cnt_ff;
   logic en_done;
   logic tx_ready_ff;
   assign en_done = (en_cnt_ff == cantrx_pkg::CNT_W'(cantrx_pkg::ENABLE_DELAY_CYC));
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         en_cnt_ff <= '0;
      end else if (mode_ff != cantrx_pkg::MODE_NORMAL) begin
         en_cnt_ff <= '0;
      end else if (!en_done) begin
         en_cnt_ff <= en_cnt_ff + 1'b1;
      end
   end
   // A recessive seen after the delay opens the driver; hides a stale low
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_ready_ff <= 1'b0;
      end else if (!en_done) begin
         tx_ready_ff <= 1'b0;
      end else if (txd) begin
         tx_ready_ff <= 1'b1;
      end
   end

   // ==========================================
   // Transmit time-out and bus clamp
   logic [cantrx_pkg::CNT_W-1:0] to_cnt_ff;
   logic [cantrx_pkg::CNT_W-1:0] cl_cnt_ff;
   logic to_ff;
   logic tx_dom;
   assign tx_dom = !txd && tx_ready_ff;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         to_cnt_ff <= '0;
         to_ff <= 1'b0;
      end else if (!tx_dom) begin
         to_cnt_ff <= '0;
         to_ff <= 1'b0;
      end else if (to_cnt_ff != cantrx_pkg::CNT_W'(cantrx_pkg::TX_TO_CYC)) begin
         to_cnt_ff <= to_cnt_ff + 1'b1;
      end else begin
         to_ff <= 1'b1;
      end
   end
   assign tx_to_evt = tx_dom && !to_ff &&
                      to_cnt_ff == cantrx_pkg::CNT_W'(cantrx_pkg::TX_TO_CYC);
   // Clamp watch only while receiving actively
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cl_cnt_ff <= '0;
      end else if (!busd || !mode_ff[1]) begin
         cl_cnt_ff <= '0;
      end else if (cl_cnt_ff != cantrx_pkg::CNT_W'(cantrx_pkg::CLAMP_CYC)) begin
         cl_cnt_ff <= cl_cnt_ff + 1'b1;
      end
   end
   assign clamp_evt = busd && mode_ff[1] &&
                      cl_cnt_ff == cantrx_pkg::CNT_W'(cantrx_pkg::CLAMP_CYC - 1);
   // Failure flag; set wins over clear-on-read
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         fail_ff <= 1'b0;
      end else if (tx_to_evt || clamp_evt) begin
         fail_ff <= 1'b1;
      end else if (rd_take && avs_address_i == cantrx_pkg::ADDR_STAT) begin
         fail_ff <= 1'b0;
      end
   end

   // ==========================================
   // Silence timer and bus outputs
   logic [cantrx_pkg::CNT_W-1:0] sil_cnt_ff;
   logic sil_done;
   assign sil_done = (sil_cnt_ff == cantrx_pkg::CNT_W'(cantrx_pkg::SILENCE_CYC));
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sil_cnt_ff <= '0;
      end else if (mode_ff != cantrx_pkg::MODE_WAKE || busd) begin
         sil_cnt_ff <= '0;
      end else if (!sil_done) begin
         sil_cnt_ff <= sil_cnt_ff + 1'b1;
      end
   end
   // Registered pin drive
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         bus_o <= '0;
         rx_data_out_o <= 1'b1;
      end else begin
         bus_o.drive_dom <= (mode_ff == cantrx_pkg::MODE_NORMAL) && tx_dom && !to_ff;
         bus_o.term_gnd <= (mode_ff == cantrx_pkg::MODE_WAKE) && sil_done && !woken_ff;
         bus_o.term_mid <= mode_ff[1] || woken_ff;
         if (woken_ff || wake_evt) begin
            rx_data_out_o <= 1'b0;
         end else if (mode_ff[1]) begin
            rx_data_out_o <= !busd;
         end else begin
            rx_data_out_o <= 1'b1;
         end
      end
   end

   // ==========================================
   // Register read mux
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         avs_readdata_o <= '0;
      end else begin
         unique case (avs_address_i)
            cantrx_pkg::ADDR_CTRL: avs_readdata_o <= {29'h0, wdwake_ff, mode_ff};
            cantrx_pkg::ADDR_STAT: avs_readdata_o <= {30'h0, to_ff, fail_ff};
            cantrx_pkg::ADDR_WAKE: avs_readdata_o <= {31'h0, wake_stat_ff};
            default: avs_readdata_o <= 32'h0;
         endcase
      end
   end

   // ==========================================
   // Assertions
   property p_off_no_wake;
      @(posedge clk_i) disable iff (rst_i) (mode_ff == cantrx_pkg::MODE_OFF) |-> !wake_evt;
   endproperty
   a_off_no_wake: assert property (p_off_no_wake) else $error("wake in off");
   property p_rxonly_nodrive;
      @(posedge clk_i) disable iff (rst_i)
         (mode_ff == cantrx_pkg::MODE_RXONLY) ##1 (mode_ff == cantrx_pkg::MODE_RXONLY)
         |-> !bus_o.drive_dom;
   endproperty
   a_rxonly_nodrive: assert property (p_rxonly_nodrive) else $error("driver on in rx only");
   property p_wake_rx_low;
      @(posedge clk_i) disable iff (rst_i) wake_evt |=> !rx_data_out_o [*3];
   endproperty
   a_wake_rx_low: assert property (p_wake_rx_low) else $error("rx not low after wake");
   property p_disarm;
      @(posedge clk_i) disable iff (rst_i)
         wake_evt && chip_mode_i == $past(chip_mode_i) |=> !armed_ff;
   endproperty
   a_disarm: assert property (p_disarm) else $error("not disarmed");
   property p_irq;
      @(posedge clk_i) disable iff (rst_i)
         wake_evt && chip_mode_i == cantrx_pkg::CHIP_STOP |=> !irq_n_out_o && wake_stat_ff;
   endproperty
   a_irq: assert property (p_irq) else $error("no irq on stop wake");
   property p_sleep_noirq;
      @(posedge clk_i) disable iff (rst_i)
         wake_evt && chip_mode_i == cantrx_pkg::CHIP_SLEEP && irq_n_out_o
         |=> irq_n_out_o && chip_wake_restart_o;
   endproperty
   a_sleep_noirq: assert property (p_sleep_noirq) else $error("sleep wake wrong");
   property p_timeout;
      @(posedge clk_i) disable iff (rst_i) tx_to_evt |=> to_ff && fail_ff ##1 !bus_o.drive_dom;
   endproperty
   a_timeout: assert property (p_timeout) else $error("time-out not handled");
   property p_mode_kept;
      @(posedge clk_i) disable iff (rst_i) tx_to_evt && !wr_ctrl |=> $stable(mode_ff);
   endproperty
   a_mode_kept: assert property (p_mode_kept) else $error("mode changed on time-out");
   property p_normal_chip;
      @(posedge clk_i) disable iff (rst_i)
         $rose(mode_ff == cantrx_pkg::MODE_NORMAL)
         |-> $past(chip_mode_i) == cantrx_pkg::CHIP_NORMAL;
   endproperty
   a_normal_chip: assert property (p_normal_chip) else $error("normal outside chip normal");
   property p_tx_resume;
      @(posedge clk_i) disable iff (rst_i) !tx_dom |=> !to_ff;
   endproperty
   a_tx_resume: assert property (p_tx_resume) else $error("transmitter not resumed");
   property p_clamp;
      @(posedge clk_i) disable iff (rst_i) clamp_evt |=> fail_ff;
   endproperty
   a_clamp: assert property (p_clamp) else $error("bus clamp not flagged");
   c_wake: cover property (@(posedge clk_i) disable iff (rst_i) wake_evt);
   c_timeout: cover property (@(posedge clk_i) disable iff (rst_i) tx_to_evt);
   c_drive: cover property (@(posedge clk_i) disable iff (rst_i) bus_o.drive_dom);
endmodule // can_trx_ctrl

/* File: sim/can_ctrl_model.sv */
// Behavioural CAN protocol controller that drives the transmit input and samples receive
`timescale 1ns/1ps
module can_ctrl_model #(
   parameter int BIT_CYC = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bench control
   input wire logic start_i,
   input wire logic [7:0] frame_i,
   input wire logic hold_low_i,
   output logic busy_o,
   output logic [7:0] seen_o,
   // Transceiver side
   input wire logic rx_i,
   output logic tx_o
);
   int bit_ff;
   int cyc_ff;
   logic [7:0] shift_ff;
   // ==========================================================
   // Frame shifter, MSB first; receive sampled late in each bit to cover loop delay
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         busy_o <= 1'b0;
         tx_o <= 1'b1;
         bit_ff <= 0;
         cyc_ff <= 0;
         seen_o <= 8'h00;
         shift_ff <= 8'h00;
      end else if (!busy_o) begin
         if (start_i) begin
            busy_o <= 1'b1;
            shift_ff <= frame_i;
            bit_ff <= 0;
            cyc_ff <= 0;
            tx_o <= frame_i[7];
         end else begin
            tx_o <= !hold_low_i;
         end
      end else begin
         cyc_ff <= (cyc_ff == BIT_CYC - 1) ? 0 : cyc_ff + 1;
         if (cyc_ff == BIT_CYC * 3 / 4)
            seen_o <= {seen_o[6:0], rx_i};
         if (cyc_ff == BIT_CYC - 1) begin
            if (bit_ff == 7) begin
               busy_o <= 1'b0;
               tx_o <= 1'b1;
            end else begin
               bit_ff <= bit_ff + 1;
               tx_o <= shift_ff[6 - bit_ff];
            end
         end
      end
   end
endmodule // can_ctrl_model

/* File: sim/can_transceiver_mode_wake_control_bench.sv */
// Self-checking bench for the CAN transceiver mode and wake control block
`timescale 1ns/1ps
module can_transceiver_mode_wake_control_bench;
   logic clk_i, rst_i, rd, wr, tx, rx, irq_n, node_dom, wd_off, wd_en, restart;
   logic [3:0] addr;
   logic [31:0] wdata, rdata;
   logic waitreq, start, hold_low, busy;
   logic [7:0] frame, seen;
   cantrx_pkg::bus_drv_t bus;
   cantrx_pkg::chip_mode_t chip;
   int bad_count, check_count, drive_cnt, wd_cnt, rst_cnt, irq_cnt;
   // ==========================================================
   // Design and controller model; bus is wired-OR of our driver and another node
   can_trx_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(addr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
      .avs_waitrequest_o(waitreq), .tx_data_in_i(tx), .rx_data_out_o(rx),
      .irq_n_out_o(irq_n), .bus_dominant_i(bus.drive_dom | node_dom), .bus_o(bus),
      .chip_mode_i(chip), .watchdog_off_i(wd_off), .watchdog_wake_en_o(wd_en),
      .chip_wake_restart_o(restart));
   can_ctrl_model #(.BIT_CYC(16)) i_ctrl (.clk_i(clk_i), .rst_i(rst_i), .start_i(start),
      .frame_i(frame), .hold_low_i(hold_low), .busy_o(busy), .seen_o(seen), .rx_i(rx),
      .tx_o(tx));
   // Clock, 20 ns period
   always #10 clk_i = ~clk_i;
   // Event counters; scenarios compare deltas
   always @(posedge clk_i) begin
      if (bus.drive_dom === 1'b1) drive_cnt++;
      if (wd_en === 1'b1) wd_cnt++;
      if (restart === 1'b1) rst_cnt++;
      if (irq_n === 1'b0) irq_cnt++;
   end
   // ==========================================================
   // Helpers
   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
      @(negedge clk_i);
   endtask
   // Hold the request until waitrequest is low at a rising edge; data is taken there
   task automatic hold_req(output logic [31:0] d);
      int n;
      logic w;
      n = 0;
      do begin
         @(negedge clk_i);
         w = waitreq;
         d = rdata;
         @(posedge clk_i);
         n++;
      end while (w !== 1'b0 && n < 100);
      if (w !== 1'b0) begin
         bad_count++;
         finish_test;
      end
   endtask
   task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] ignored;
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      hold_req(ignored);
      wr <= 1'b0;
      @(negedge clk_i);
   endtask
   // Read data stands in the cycle before the accepting edge
   task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      hold_req(d);
      rd <= 1'b0;
      @(negedge clk_i);
   endtask
   task automatic set_chip(input cantrx_pkg::chip_mode_t m);
      @(posedge clk_i);
      chip <= m;
      @(negedge clk_i);
   endtask
   // Dominant, recessive, dominant phases in cycles, then settle
   task automatic pattern(input int d1, input int r, input int d2);
      @(posedge clk_i);
      node_dom <= 1'b1;
      repeat (d1) @(posedge clk_i);
      node_dom <= 1'b0;
      repeat (r) @(posedge clk_i);
      node_dom <= 1'b1;
      repeat (d2) @(posedge clk_i);
      node_dom <= 1'b0;
      idle(20);
   endtask
   task automatic send(input logic [7:0] f);
      int n;
      @(posedge clk_i);
      frame <= f;
      start <= 1'b1;
      @(posedge clk_i);
      start <= 1'b0;
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (busy === 1'b1 && n < 400);
      if (busy === 1'b1) begin
         bad_count++;
         finish_test;
      end else begin
         idle(10);
      end
   endtask
   // Bound on the whole run
   initial begin
      repeat (90000) @(posedge clk_i);
      bad_count++;
      finish_test;
   end
   // ==========================================================
   // Main sequence
   initial begin
      logic [31:0] r;
      int d;
      clk_i = 1'b0;
      rst_i = 1'b1;
      rd = 1'b0;
      wr = 1'b0;
      addr = 4'h0;
      wdata = 32'h0;
      node_dom = 1'b0;
      wd_off = 1'b1;
      start = 1'b0;
      hold_low = 1'b0;
      frame = 8'h00;
      chip = cantrx_pkg::CHIP_STOP;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      // Power-up state and wake ignored while off
      bus_read(cantrx_pkg::ADDR_CTRL, r);
      check(32'(r[1:0]), 32'(cantrx_pkg::MODE_OFF));
      pattern(100, 100, 100);
      check(32'(rx), 32'h1);
      check(32'(irq_n), 32'h1);
      bus_read(cantrx_pkg::ADDR_WAKE, r);
      check(32'(r[0]), 32'h0);
      $display("Test off mode done");
      // Mode gating and receive only
      bus_write(cantrx_pkg::ADDR_CTRL, 32'(cantrx_pkg::MODE_NORMAL));
      bus_read(cantrx_pkg::ADDR_CTRL, r);
      check(32'(r[1:0]), 32'(cantrx_pkg::MODE_OFF));
      bus_write(cantrx_pkg::ADDR_CTRL, 32'(cantrx_pkg::MODE_RXONLY));
      bus_read(cantrx_pkg::ADDR_CTRL, r);
      check(32'(r[1:0]), 32'(cantrx_pkg::MODE_RXONLY));
      @(posedge clk_i);
      node_dom <= 1'b1;
      idle(10);
      check(32'(rx), 32'h0);
      @(posedge clk_i);
      node_dom <= 1'b0;
      idle(10);
      check(32'(rx), 32'h1);
      d = drive_cnt;
      send(8'h00);
      check(32'(drive_cnt - d), 32'h0);
      check(32'(seen), 32'hFF);
      set_chip(cantrx_pkg::CHIP_SLEEP);
      bus_write(cantrx_pkg::ADDR_CTRL, 32'(cantrx_pkg::MODE_OFF));
      bus_write(cantrx_pkg::ADDR_CTRL, 32'(cantrx_pkg::MODE_RXONLY));
      bus_read(cantrx_pkg::ADDR_CTRL, r);
      check(32'(r[1:0]), 32'(cantrx_pkg::MODE_OFF));
      $display("Test mode gating done");
      // Normal mode: stale dominant across enable delay is not sent
      set_chip(cantrx_pkg::CHIP_NORMAL);
      @(posedge clk_i);
      hold_low <= 1'b1;
      d = drive_cnt;
      bus_write(cantrx_pkg::ADDR_CTRL, 32'(cantrx_pkg::MODE_NORMAL));
      bus_read(cantrx_pkg::ADDR_CTRL, r);
      check(32'(r[1:0]), 32'(cantrx_pkg::MODE_NORMAL));
      idle(cantrx_pkg::ENABLE_DELAY_CYC + 20);
      check(32'(drive_cnt - d), 32'h0);
      @(posedge clk_i);
      hold_low <= 1'b0;
      idle(5);
      d = drive_cnt;
      send(8'hA5);
      check(32'(seen), 32'hA5);
      check(32'(drive_cnt - d), 32'd64);
      $display("Test normal mode done");
      // Wake in chip stop: filter, report, watchdog, disarm
      set_chip(cantrx_pkg::CHIP_STOP);
      bus_write(cantrx_pkg::ADDR_CTRL, 32'h5);
      idle(20);
      check(32'(bus.term_gnd), 32'h0);
      d = wd_cnt;
      pattern(20, 100, 100);
      check(32'(rx), 32'h1);
      pattern(100, 100, 100);
      check(32'(rx), 32'h0);
      check(32'(irq_n), 32'h0);
      check(32'(bus.term_mid), 32'h1);
      check(32'(bus.term_gnd), 32'h0);
      check(32'(wd_cnt - d), 32'h1);
      bus_read(cantrx_pkg::ADDR_CTRL, r);
      check(32'(r[1:0]), 32'(cantrx_pkg::MODE_WAKE));
      bus_read(cantrx_pkg::ADDR_WAKE, r);
      check(32'(r[0]), 32'h1);
      idle(3);
      check(32'(irq_n), 32'h1);
      pattern(100, 100, 100);
      bus_read(cantrx_pkg::ADDR_WAKE, r);
      check(32'(r[0]), 32'h0);
      $display("Test stop wake done");
      // Chip sleep rearms; wake restarts the chip without interrupt
      d = irq_cnt;
      r = 32'(rst_cnt);
      set_chip(cantrx_pkg::CHIP_SLEEP);
      pattern(100, 100, 100);
      check(32'(rst_cnt) - r, 32'h1);
      check(32'(irq_cnt - d), 32'h0);
      check(32'(rx), 32'h0);
      $display("Test sleep wake done");
      // Toggle rearm in chip normal
      set_chip(cantrx_pkg::CHIP_NORMAL);
      bus_write(cantrx_pkg::ADDR_CTRL, 32'(cantrx_pkg::MODE_OFF));
      idle(5);
      check(32'(rx), 32'h1);
      bus_read(cantrx_pkg::ADDR_WAKE, r);
      bus_write(cantrx_pkg::ADDR_CTRL, 32'h5);
      pattern(100, 100, 100);
      check(32'(irq_n), 32'h0);
      bus_read(cantrx_pkg::ADDR_WAKE, r);
      check(32'(r[0]), 32'h1);
      $display("Test rearm done");
      // Fail-safe forces wake capable
      bus_write(cantrx_pkg::ADDR_CTRL, 32'(cantrx_pkg::MODE_OFF));
      set_chip(cantrx_pkg::CHIP_FAILSAFE);
      idle(5);
      bus_read(cantrx_pkg::ADDR_CTRL, r);
      check(32'(r[1:0]), 32'(cantrx_pkg::MODE_WAKE));
      idle(cantrx_pkg::SILENCE_CYC + 5);
      check(32'(bus.term_gnd), 32'h1);
      check(32'(bus.term_mid), 32'h0);
      $display("Test fail-safe done");
      finish_test;
   end
endmodule // can_transceiver_mode_wake_control_bench
